// [rtl/fsp_pkg.sv]
// Constants and carriers for the frame-timing synchronisation port block.
// Assumes a 10 MHz station clock (100 ns period).
package fsp_pkg;

  // ------------------------------------------------------------
  // Clock and times
  // ------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int SHORT_MIN_NS = 5000;       // 5 us
  localparam int SHORT_MAX_NS = 1000000;    // 1 ms
  localparam int LONG_MIN_NS = 2000000;     // 2 ms
  localparam int LONG_MAX_NS = 5000000;     // 5 ms
  localparam int FRAME_NS = 10000000;       // 10 ms
  localparam int TICK_NS = 125000;          // 0.125 ms stamp step
  localparam int FRAME_MARGIN_NS = 100000;  // slack on frame gap

  // Least times round up, longest round down
  localparam int SHORT_MIN_CYC = (SHORT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHORT_MAX_CYC = SHORT_MAX_NS / CLK_NS;
  localparam int LONG_MIN_CYC = (LONG_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_MAX_CYC = LONG_MAX_NS / CLK_NS;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int FRAME_MAX_CYC = (FRAME_NS + FRAME_MARGIN_NS) / CLK_NS;

  // ------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int TICK_W = 12;
  localparam int STAMP_W = 19;              // 0 .. 327679 ticks
  localparam int FRAMES_PER_MF = 256;
  localparam int TICKS_PER_FRAME = 80;
  localparam logic [STAMP_W-1:0] STAMP_LAST = 19'h4ffff;
  localparam logic [7:0] FRAME_LAST = 8'hff;
  localparam int GOOD_MF_NEEDED = 1;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FSP_HUNT = 2'b00,   // waiting for first long pulse
    FSP_LOCK = 2'b01,   // frame timing following input
    FSP_LOST = 2'b11    // input judged invalid
  } fsp_state_e;

  typedef struct packed {
    logic [STAMP_W-1:0] request_send_stamp;
    logic [STAMP_W-1:0] receive_stamp;
    logic [STAMP_W-1:0] reply_send_stamp;
  } fsp_reply_s;

  typedef struct packed {
    logic frame_start;
    logic multiframe_start;
    logic [7:0] frame_count;
    logic valid;
  } fsp_timing_s;

endpackage : fsp_pkg

// [rtl/fsp_pulse_meas.sv]
// Measures pulses on the synchronised sync input and classifies them.
// Assumes the input is already on the station clock.
`timescale 1ns/1ns
module fsp_pulse_meas (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_level,
  output logic fall_short,
  output logic fall_long,
  output logic fall_bad
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] width;
    logic last;
    logic short_p;
    logic long_p;
    logic bad_p;
  } fsp_meas_s;

  fsp_meas_s q, next_q;

  // ------------------------------------------------------------
  // Width counter and falling-edge classification
  // ------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.last = sync_level;
    next_q.short_p = 1'b0;
    next_q.long_p = 1'b0;
    next_q.bad_p = 1'b0;
    if (sync_level && !q.last) begin
      next_q.width = CNT_W'(1);
    end else if (sync_level && q.width != {CNT_W{1'b1}}) begin
      next_q.width = q.width + CNT_W'(1);
    end
    if (!sync_level && q.last) begin
      if (q.width >= CNT_W'(SHORT_MIN_CYC) &&
          q.width <= CNT_W'(SHORT_MAX_CYC)) begin
        next_q.short_p = 1'b1;
      end else if (q.width >= CNT_W'(LONG_MIN_CYC) &&
                   q.width <= CNT_W'(LONG_MAX_CYC)) begin
        next_q.long_p = 1'b1;         // Multiframe marker class
      end else begin
        next_q.bad_p = 1'b1;          // Outside both ranges
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign fall_short = q.short_p;
  assign fall_long = q.long_p;
  assign fall_bad = q.bad_p;

endmodule : fsp_pulse_meas

// [rtl/fsp_sync_port.sv]
// Sync-port frame timing: decodes the pulse-coded sync input, keeps frame
// and multiframe counters, regenerates the pulse on the sync output while locked and
// answers node-synchronisation requests with station frame-number stamps.
// Assumes sync_input_port is asynchronous; request strobes are on clk.
`timescale 1ns/1ns

module fsp_sync_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sync_input_port,
  input wire logic req_valid,
  input wire logic [fsp_pkg::STAMP_W-1:0] req_request_send_stamp,
  input wire logic reply_ready,
  output logic sync_output_port,
  output fsp_pkg::fsp_timing_s timing,
  output logic [fsp_pkg::STAMP_W-1:0] station_frame_number,
  output logic req_ready,
  output logic reply_valid,
  output fsp_pkg::fsp_reply_s reply
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [2:0] in_sync;
    logic level;
    fsp_state_e state;
    logic [CNT_W-1:0] gap;
    logic [TICK_W-1:0] tick_cnt;
    logic [STAMP_W-1:0] sfn_time;
    logic [7:0] frame_cnt;
    logic frame_start;
    logic mf_start;
    logic out_pin;
    logic busy;
    logic rvalid;
    logic vld;                  // Registered copy of the locked state
    logic ready;                // Registered request ready
    fsp_reply_s rep;
  } fsp_top_s;

  fsp_top_s q, next_q;
  logic rst_n;
  logic fall_short;
  logic fall_long;
  logic fall_bad;
  logic fall_any;
  logic sync_now;

  // ------------------------------------------------------------
  // Reset release and pulse measurement
  // ------------------------------------------------------------
  logic [1:0] rst_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Agreed input level, taken as soon as stages two and three agree;
  // skipping the extra level flop keeps the fall-to-frame delay at 500 ns
  assign sync_now = (q.in_sync[1] == q.in_sync[2]) ? q.in_sync[2] : q.level;

  fsp_pulse_meas u_meas (
    .clk(clk),
    .rst_n(rst_n),
    .sync_level(sync_now),
    .fall_short(fall_short),
    .fall_long(fall_long),
    .fall_bad(fall_bad)
  );
  assign fall_any = fall_short | fall_long;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.frame_start = 1'b0;
    next_q.mf_start = 1'b0;
    // Three-stage input synchroniser; stage 0 feeds only stage 1
    next_q.in_sync = {q.in_sync[1:0], sync_input_port};
    if (q.in_sync[1] == q.in_sync[2]) begin
      next_q.level = q.in_sync[2];
    end

    // Station time base in 0.125 ms ticks
    if (q.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
      next_q.tick_cnt = '0;
      next_q.sfn_time = (q.sfn_time == STAMP_LAST) ? '0
                        : q.sfn_time + STAMP_W'(1);
    end else begin
      next_q.tick_cnt = q.tick_cnt + TICK_W'(1);
    end
    // Free-running frame when not locked
    if (q.state != FSP_LOCK && q.tick_cnt == TICK_W'(TICK_CYC - 1) &&
        q.sfn_time % STAMP_W'(TICKS_PER_FRAME) ==
        STAMP_W'(TICKS_PER_FRAME - 1)) begin
      next_q.frame_start = 1'b1;
      next_q.frame_cnt = q.frame_cnt + 8'h1;
      next_q.mf_start = (q.frame_cnt == FRAME_LAST);
    end

    // Missing-pulse watchdog
    if (fall_any) begin
      next_q.gap = '0;
    end else if (q.gap != CNT_W'(FRAME_MAX_CYC)) begin
      next_q.gap = q.gap + CNT_W'(1);
    end

    case (q.state)
      FSP_HUNT, FSP_LOST: begin
        // Lock only on a clean long pulse
        if (fall_long) begin
          next_q.state = FSP_LOCK;
          next_q.frame_start = 1'b1;
          next_q.mf_start = 1'b1;
          next_q.frame_cnt = '0;
          next_q.tick_cnt = '0;
          next_q.sfn_time = q.sfn_time - q.sfn_time %
                            STAMP_W'(TICKS_PER_FRAME * FRAMES_PER_MF);
        end
      end
      FSP_LOCK: begin
        if (fall_bad || q.gap == CNT_W'(FRAME_MAX_CYC)) begin
          next_q.state = FSP_LOST;
        end else if (fall_long && q.frame_cnt != FRAME_LAST) begin
          next_q.state = FSP_LOST;
        end else if (fall_any) begin
          // Frame boundary taken from the falling edge
          next_q.frame_start = 1'b1;
          next_q.mf_start = fall_long;
          next_q.frame_cnt = fall_long ? '0 : q.frame_cnt + 8'h1;
          next_q.tick_cnt = '0;
          next_q.sfn_time = q.sfn_time - q.sfn_time %
                            STAMP_W'(TICKS_PER_FRAME) +
                            STAMP_W'(TICKS_PER_FRAME);
          if (next_q.sfn_time > STAMP_LAST) begin
            next_q.sfn_time = '0;
          end
        end
      end
      default: next_q.state = FSP_HUNT;
    endcase

    // Regenerated output only while the state one cycle earlier was FSP_LOCK
    next_q.out_pin = (q.state == FSP_LOCK) && q.level;

    // Node-synchronisation request and reply
    if (req_valid && q.ready) begin
      next_q.busy = 1'b1;
      next_q.rep.request_send_stamp = req_request_send_stamp;
      next_q.rep.receive_stamp = q.sfn_time;
    end else if (q.busy && !q.rvalid) begin
      next_q.rvalid = 1'b1;
      next_q.rep.reply_send_stamp = q.sfn_time;
    end else if (q.rvalid && reply_ready) begin
      next_q.rvalid = 1'b0;
      next_q.busy = 1'b0;
    end

    // Status outputs held in flops of their own
    next_q.ready = !next_q.busy;
    next_q.vld = (next_q.state == FSP_LOCK);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= FSP_HUNT;
    end else begin
      q <= next_q;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all from flip-flops
  // ------------------------------------------------------------
  assign sync_output_port = q.out_pin;
  assign timing.frame_start = q.frame_start;
  assign timing.multiframe_start = q.mf_start;
  assign timing.frame_count = q.frame_cnt;
  assign timing.valid = q.vld;
  assign station_frame_number = q.sfn_time;
  assign req_ready = q.ready;
  assign reply_valid = q.rvalid;
  assign reply = q.rep;

endmodule : fsp_sync_port

// [tb/fsp_sync_source.sv]
// Model of the reference that drives the pulse-coded sync wire.
// Assumes the bench chooses every pulse width and gap.
`timescale 1ns/1ns
module fsp_sync_source (
  input wire logic clk,
  output logic sync_input_port
);
  // Wire idles low between pulses
  initial sync_input_port = 1'b0;
  // Set level after an edge, hold it for a count of edges
  task automatic drive(input logic lvl, input int cycles);
    @(posedge clk);
    sync_input_port <= lvl;
    repeat (cycles) @(posedge clk);
  endtask : drive
endmodule : fsp_sync_source

// [tb/fsp_sync_port_monitor.sv]
// Port checker for the sync port block.
// Assumes binding to every instance of fsp_sync_port.
`timescale 1ns/1ns
module fsp_sync_port_monitor
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sync_input_port,
  input wire logic req_valid,
  input wire logic [STAMP_W-1:0] req_request_send_stamp,
  input wire logic reply_ready,
  input wire logic sync_output_port,
  input wire fsp_timing_s timing,
  input wire logic [STAMP_W-1:0] station_frame_number,
  input wire logic req_ready,
  input wire logic reply_valid,
  input wire fsp_reply_s reply
);
  logic prev_in;
  logic [3:0] since_fall;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Edges since the last fall of the sync wire
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_in <= 1'b0;
      since_fall <= 4'hf;
    end else begin
      prev_in <= sync_input_port;
      if (prev_in && !sync_input_port)
        since_fall <= 4'h0;
      else if (since_fall != 4'hf)
        since_fall <= since_fall + 4'h1;
    end
  end
  AST_MF_FS: assert property (
    timing.multiframe_start |-> timing.frame_start)
    else $error("multiframe start alone");
  AST_MF_ZERO: assert property (
    timing.multiframe_start |-> timing.frame_count == 8'h00)
    else $error("multiframe start not at frame zero");
  AST_FALL_DELAY: assert property (
    timing.frame_start && timing.valid |-> since_fall <= 4'h4)
    else $error("frame start late after fall");
  AST_COUNT_STEP: assert property (
    timing.frame_start && !timing.multiframe_start && timing.valid
    && $past(timing.valid)
    |-> timing.frame_count == $past(timing.frame_count) + 8'h01)
    else $error("frame count skipped");
  AST_OUT_GATED: assert property (
    !timing.valid && !$past(timing.valid) |-> !sync_output_port)
    else $error("output pulses while unlocked");
  AST_OUT_FOLLOW: assert property (
    timing.valid && $rose(sync_input_port) |-> ##[2:6] sync_output_port)
    else $error("output does not follow input");
  AST_TAKE: assert property (
    req_valid && req_ready |=> !req_ready ##1 reply_valid)
    else $error("reply not on time");
  AST_ECHO: assert property (
    req_valid && req_ready |-> ##2
    reply.request_send_stamp == $past(req_request_send_stamp, 2))
    else $error("request stamp altered");
  AST_HOLD: assert property (
    reply_valid && !reply_ready |=> reply_valid && $stable(reply))
    else $error("reply dropped before accept");
  // Main scenarios reached
  cover property (timing.multiframe_start && timing.valid);
  cover property (reply_valid && reply_ready);
  cover property (timing.valid ##1 !timing.valid);
endmodule : fsp_sync_port_monitor

bind fsp_sync_port fsp_sync_port_monitor i_mon (.clk(clk), .resetn(resetn),
  .sync_input_port(sync_input_port), .req_valid(req_valid),
  .req_request_send_stamp(req_request_send_stamp), .reply_ready(reply_ready),
  .sync_output_port(sync_output_port), .timing(timing), .reply(reply),
  .station_frame_number(station_frame_number), .req_ready(req_ready),
  .reply_valid(reply_valid));

// [tb/frame_sync_port_timing_test.sv]
// Self-checking bench for the sync port block.
// Assumes fsp_pkg, the design and the reference model are compiled first.
`timescale 1ns/1ns
module frame_sync_port_timing_test;
  import fsp_pkg::*;
  logic clk;
  logic resetn;
  logic sync_input_port;
  logic req_valid;
  logic reply_ready;
  logic sync_output_port;
  logic req_ready;
  logic reply_valid;
  logic [STAMP_W-1:0] req_request_send_stamp;
  logic [STAMP_W-1:0] station_frame_number;
  fsp_timing_s timing;
  fsp_reply_s reply;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  fsp_sync_port i_dut (.clk(clk), .resetn(resetn),
    .sync_input_port(sync_input_port), .req_valid(req_valid),
    .req_request_send_stamp(req_request_send_stamp),
    .reply_ready(reply_ready), .sync_output_port(sync_output_port),
    .timing(timing), .station_frame_number(station_frame_number),
    .req_ready(req_ready), .reply_valid(reply_valid), .reply(reply));
  fsp_sync_source i_src (.clk(clk), .sync_input_port(sync_input_port));

  // 10 MHz clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic cmp(input logic [STAMP_W-1:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // Request, stalled consumer, then accept
  task automatic t_reply(input logic [STAMP_W-1:0] stamp);
    logic [STAMP_W-1:0] t_take;
    int n;
    req_valid <= 1'b1;
    req_request_send_stamp <= stamp;
    @(posedge clk);
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(posedge clk);
    t_take = station_frame_number;
    req_valid <= 1'b0;
    for (n = 0; n < 20 && reply_valid !== 1'b1; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    cmp(reply_valid, 1'b1);
    cmp(reply.request_send_stamp, stamp);
    cmp(reply.receive_stamp, t_take);
    cmp(reply.reply_send_stamp >= t_take, 1'b1);
    reply_ready <= 1'b1;
    @(posedge clk);
    reply_ready <= 1'b0;
    @(posedge clk);
    cmp(reply_valid, 1'b0);
    $display("reply test done");
  endtask : t_reply

  // Long pulse brings lock at its falling edge
  task automatic t_lock;
    int n;
    cmp(timing.valid, 1'b0);
    i_src.drive(1'b1, 25000);
    cmp(sync_output_port, 1'b0);
    i_src.drive(1'b0, 0);
    for (n = 0; n < 9 && timing.frame_start !== 1'b1; n++) @(posedge clk);
    cmp(n <= 6, 1'b1);
    cmp(timing.multiframe_start, 1'b1);
    cmp(timing.frame_count, 8'h00);
    cmp(timing.valid, 1'b1);
    $display("lock test done");
  endtask : t_lock

  // Short pulse regenerated and counted as next frame
  task automatic t_short;
    int n;
    i_src.drive(1'b0, 100);
    i_src.drive(1'b1, 500);
    cmp(sync_output_port, 1'b1);
    i_src.drive(1'b0, 0);
    for (n = 0; n < 9 && timing.frame_start !== 1'b1; n++) @(posedge clk);
    cmp(timing.frame_count, 8'h01);
    cmp(timing.multiframe_start, 1'b0);
    $display("short pulse test done");
  endtask : t_short

  // Long pulse away from the multiframe boundary
  task automatic t_off_boundary;
    i_src.drive(1'b0, 100);
    i_src.drive(1'b1, 25000);
    i_src.drive(1'b0, 10);
    cmp(timing.valid, 1'b0);
    cmp(sync_output_port, 1'b0);
    $display("boundary test done");
  endtask : t_off_boundary

  // Pulse too narrow for either class
  task automatic t_bad;
    i_src.drive(1'b0, 100);
    i_src.drive(1'b1, 30);
    i_src.drive(1'b0, 10);
    cmp(timing.valid, 1'b0);
    $display("bad width test done");
  endtask : t_bad

  task automatic end_of_test;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    reply_ready = 1'b0;
    req_request_send_stamp = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    t_reply(19'h4ffff);
    t_reply(19'h00000);
    t_lock();
    t_short();
    t_off_boundary();
    t_lock();
    t_bad();
    end_of_test();
  end
endmodule : frame_sync_port_timing_test
